// ### hdl/contact_speed_select.sv
/*
 contact input preset speed selection with soft start ramps,
 registers on an apb slave.
 assumes active-low contact pins from a switch panel, one 10 mhz clock,
 and downstream speed, clamp and pulse logic that obey refMode.
*/
// The address map and the APB interface to the registers were left to the implementer.
// Operation
// - contact speed control active only while function switch bit 2 is 1
// - when disabled, direction contact picks p control, selects are torque limits
// - when enabled, direction contact off runs forward, on runs reverse
// - selects 01 first, 11 second, 10 third, 00 stop path
// - three preset speeds, zero to maximum, reset to 100, 200, 300
// - position variant, both off: stop if bit f is 0, pulse if 1
// - reference pulse blocking has no effect while contact control enabled
// - acceleration ramp time in ms, 0 to 10000, covers zero to maximum
// - deceleration ramp time in ms, 0 to 10000, covers maximum to zero
// - both ramp times zero pass the command straight through
// - stepwise speed changes are softened at programmed rates
// - position variant ramps only under contact control, never pulse reference
// - monitor bits 7 and 8 change meaning with the enable bit
// - don't-care mode bits and inputs never alter the selected speed
// - speed variant keeps analog reference usable through mode bits a and b
// - contact change reaches the selection within 6 ms
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"

module contact_speed_select
	import css_pkg::*;
#(
	parameter bit POSITION_VARIANT = 1'b0,
	parameter int MAX_SPEED_RPM    = `CSS_MAX_SPEED_RPM,
	parameter int CLK_PER_MS       = `CSS_CLK_PER_MS
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// apb slave
	input  wire logic [7:0]   paddr,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  pwdata,
	output var  logic [31:0]  prdata,
	output var  logic         pready,
	output var  logic         pslverr,
	// contact pins, low level means on
	input  wire logic         directionSelectInputN,
	input  wire logic         speedSelectFirstInputN,
	input  wire logic         speedSelectSecondInputN,
	input  wire logic         referenceBlockInputN,
	// drive side
	output var  speed_type    speedCommand,
	output var  logic         reverseRun,
	output var  logic         propControl,
	output var  logic         fwdTorqueLimit,
	output var  logic         revTorqueLimit,
	output var  ref_mode_type refMode,
	output var  logic         referenceBlock,
	output var  logic         rampBusy
);

	typedef struct packed {
		logic [15:0]  funcSw;
		logic [15:0]  modeSw;
		logic [15:0]  first_preset_speed;
		logic [15:0]  second_preset_speed;
		logic [15:0]  third_preset_speed;
		logic [13:0]  accelMs;
		logic [13:0]  decelMs;
		speed_type    cmd;
		logic [31:0]  acc;
		logic         reverse;
		logic         pCtl;
		logic         fTl;
		logic         rTl;
		logic         refBlk;
		ref_mode_type mode;
		logic [31:0]  rdata;
	} state_type;

	state_type q;
	state_type d;

	logic [3:0]  pinSync;
	logic        dirOn;
	logic        sel1On;
	logic        sel2On;
	logic        blkOn;
	logic        enable;
	logic        hit;
	logic        wrEn;
	logic        rdSetup;
	logic        applyRamp;
	logic        up;
	logic        decel;
	logic [15:0] mag;
	logic [13:0] rampMs;
	logic [31:0] thr;
	logic [31:0] sum;
	logic [31:0] rdVal;
	speed_type   target;

	// contacts are asynchronous to clk_sys
	contact_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pinIn   ({referenceBlockInputN, speedSelectSecondInputN,
			speedSelectFirstInputN, directionSelectInputN}),
		.pinSync (pinSync)
	);

	assign dirOn  = ~pinSync[0];
	assign sel1On = ~pinSync[1];
	assign sel2On = ~pinSync[2];
	assign blkOn  = ~pinSync[3];
	assign enable = q.funcSw[`CSS_FUNC_CONTACT_EN];

	// apb decode: zero wait state, read data captured in the setup cycle
	always_comb begin
		case (paddr)
			`CSS_OFS_FUNC_SW,
			`CSS_OFS_MODE_SW,
			`CSS_OFS_FIRST_PRESET_SPEED,
			`CSS_OFS_SECOND_PRESET_SPEED,
			`CSS_OFS_THIRD_PRESET_SPEED,
			`CSS_OFS_ACCEL,
			`CSS_OFS_DECEL,
			`CSS_OFS_MONITOR,
			`CSS_OFS_STATUS: hit = 1'b1;
			default:         hit = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wrEn    = psel & penable & pwrite & hit;
	assign rdSetup = psel & ~penable & ~pwrite;

	// read mux
	always_comb begin
		rdVal = 32'h0000_0000;
		case (paddr)
			`CSS_OFS_FUNC_SW: rdVal[15:0] = q.funcSw;
			`CSS_OFS_MODE_SW: rdVal[15:0] = q.modeSw;
			`CSS_OFS_FIRST_PRESET_SPEED:  rdVal[15:0] = q.first_preset_speed;
			`CSS_OFS_SECOND_PRESET_SPEED:  rdVal[15:0] = q.second_preset_speed;
			`CSS_OFS_THIRD_PRESET_SPEED:  rdVal[15:0] = q.third_preset_speed;
			`CSS_OFS_ACCEL:   rdVal[13:0] = q.accelMs;
			`CSS_OFS_DECEL:   rdVal[13:0] = q.decelMs;
			`CSS_OFS_MONITOR: begin
				rdVal[`CSS_MON_DIR] = dirOn;
				// enabled: speed selects; disabled: torque limit inputs
				if (enable) begin
					rdVal[`CSS_MON_SEL_LO] = sel1On;
					rdVal[`CSS_MON_SEL_HI] = sel2On;
				end else begin
					rdVal[`CSS_MON_SEL_LO] = q.fTl;
					rdVal[`CSS_MON_SEL_HI] = q.rTl;
				end
			end
			`CSS_OFS_STATUS: begin
				rdVal[15:0] = q.cmd;
				rdVal[`CSS_STAT_REVERSE] = q.reverse;
				rdVal[`CSS_STAT_MODE_LO +: 3] = q.mode;
				rdVal[`CSS_STAT_RAMPING] = (q.cmd != target);
			end
			default: rdVal = 32'h0000_0000;
		endcase
	end

	// selection of the reference path
	always_comb begin
		d       = q;
		mag     = 16'h0000;
		d.pCtl  = 1'b0;
		d.fTl   = 1'b0;
		d.rTl   = 1'b0;
		d.refBlk = 1'b0;
		if (!enable) begin
			d.mode    = REF_STANDARD;
			d.reverse = 1'b0;
			d.pCtl    = dirOn;
			d.fTl     = sel1On;
			d.rTl     = sel2On;
			d.refBlk  = POSITION_VARIANT & blkOn;
		end else begin
			d.reverse = dirOn;
			// blocking input ignored while enabled
			// only the rows named below matter; the rest are don't care
			case ({sel1On, sel2On})
				2'b01: begin
					d.mode = REF_PRESET;
					mag    = q.first_preset_speed;
				end
				2'b11: begin
					d.mode = REF_PRESET;
					mag    = q.second_preset_speed;
				end
				2'b10: begin
					d.mode = REF_PRESET;
					mag    = q.third_preset_speed;
				end
				default: begin
					if (POSITION_VARIANT) begin
						if (q.modeSw[`CSS_MODE_BIT_F]) begin
							d.mode = REF_PULSE;
						end else begin
							d.mode = REF_STOP;
						end
					end else if (q.modeSw[`CSS_MODE_BIT_B]) begin
						d.mode = REF_ANALOG;
					end else if (q.modeSw[`CSS_MODE_BIT_A]) begin
						d.mode = REF_CLAMP;
					end else begin
						d.mode = REF_STOP;
					end
				end
			endcase
		end
		if (d.reverse) begin
			target = speed_type'(16'h0000 - mag);
		end else begin
			target = speed_type'(mag);
		end

		// soft start ramp, one 1 r/min step whenever the accumulator overflows
		applyRamp = POSITION_VARIANT ? (d.mode == REF_PRESET) : 1'b1;
		up    = (target > q.cmd);
		decel = (q.cmd > 0 && !up) || (q.cmd < 0 && up);
		rampMs = decel ? q.decelMs : q.accelMs;
		thr   = 32'(rampMs) * 32'(CLK_PER_MS);
		sum   = q.acc + 32'(MAX_SPEED_RPM);
		if (!applyRamp || q.cmd == target) begin
			d.cmd = applyRamp ? q.cmd : target;
			d.acc = 32'h0000_0000;
		end else if (rampMs == 14'h0000) begin
			d.cmd = target;
			d.acc = 32'h0000_0000;
		end else if (sum >= thr) begin
			// maximum speed per ramp time, spread over clocks
			d.acc = sum - thr;
			d.cmd = up ? speed_type'(q.cmd + 16'sd1) : speed_type'(q.cmd - 16'sd1);
		end else begin
			d.acc = sum;
		end

		// register writes, values above range are clamped
		if (wrEn) begin
			case (paddr)
				`CSS_OFS_FUNC_SW: d.funcSw = pwdata[15:0];
				`CSS_OFS_MODE_SW: d.modeSw = pwdata[15:0];
				`CSS_OFS_FIRST_PRESET_SPEED: begin
					d.first_preset_speed = (pwdata[15:0] > 16'(MAX_SPEED_RPM)) ?
						16'(MAX_SPEED_RPM) : pwdata[15:0];
				end
				`CSS_OFS_SECOND_PRESET_SPEED: begin
					d.second_preset_speed = (pwdata[15:0] > 16'(MAX_SPEED_RPM)) ?
						16'(MAX_SPEED_RPM) : pwdata[15:0];
				end
				`CSS_OFS_THIRD_PRESET_SPEED: begin
					d.third_preset_speed = (pwdata[15:0] > 16'(MAX_SPEED_RPM)) ?
						16'(MAX_SPEED_RPM) : pwdata[15:0];
				end
				`CSS_OFS_ACCEL: begin
					d.accelMs = (pwdata[15:0] > 16'(`CSS_RAMP_MAX_MS)) ?
						`CSS_RAMP_MAX_MS : pwdata[13:0];
				end
				`CSS_OFS_DECEL: begin
					d.decelMs = (pwdata[15:0] > 16'(`CSS_RAMP_MAX_MS)) ?
						`CSS_RAMP_MAX_MS : pwdata[13:0];
				end
				default: d.rdata = q.rdata;
			endcase
		end
		if (rdSetup) begin
			d.rdata = rdVal;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q         <= '0;
			q.funcSw  <= `CSS_RST_FUNC_SW;
			q.modeSw  <= `CSS_RST_MODE_SW;
			q.first_preset_speed  <= `CSS_RST_FIRST_PRESET_SPEED;
			q.second_preset_speed  <= `CSS_RST_SECOND_PRESET_SPEED;
			q.third_preset_speed  <= `CSS_RST_THIRD_PRESET_SPEED;
			q.accelMs <= `CSS_RST_ACCEL;
			q.decelMs <= `CSS_RST_DECEL;
			q.mode    <= REF_STANDARD;
		end else begin
			q <= d;
		end
	end

	assign prdata         = q.rdata;
	assign speedCommand   = q.cmd;
	assign reverseRun     = q.reverse;
	assign propControl    = q.pCtl;
	assign fwdTorqueLimit = q.fTl;
	assign revTorqueLimit = q.rTl;
	assign refMode        = q.mode;
	assign referenceBlock = q.refBlk;
	assign rampBusy       = (q.cmd != target);

endmodule

`default_nettype wire

// ### hdl/contact_sync.sv
/*
 two-stage synchroniser for the contact pins;
 assumes asynchronous pins and one clock, clk_sys
*/
`timescale 1ns/1ps
`default_nettype none

module contact_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// raw pins and synchronised levels
	input  wire logic [WIDTH-1:0] pinIn,
	output var  logic [WIDTH-1:0] pinSync
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_type;

	sync_state_type q;
	sync_state_type d;

	// stage1 is read by stage2 only
	always_comb begin
		d        = q;
		d.stage1 = pinIn;
		d.stage2 = q.stage1;
	end

	// idle contacts read high (off) so reset releases into a quiet state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '{stage1: '1, stage2: '1};
		end else begin
			q <= d;
		end
	end

	assign pinSync = q.stage2;

endmodule

`default_nettype wire

// ### include/css_defines.svh
/*
 offsets, field positions, reset values and timing counts of the
 contact speed selection block; assumes inclusion by bare name only
*/
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// register byte offsets on the apb bus
`define CSS_OFS_FUNC_SW      8'h00
`define CSS_OFS_MODE_SW      8'h04
`define CSS_OFS_FIRST_PRESET_SPEED       8'h08
`define CSS_OFS_SECOND_PRESET_SPEED       8'h0c
`define CSS_OFS_THIRD_PRESET_SPEED       8'h10
`define CSS_OFS_ACCEL        8'h14
`define CSS_OFS_DECEL        8'h18
`define CSS_OFS_MONITOR      8'h1c
`define CSS_OFS_STATUS       8'h20

// field positions
`define CSS_FUNC_CONTACT_EN  2
`define CSS_MODE_BIT_A       10
`define CSS_MODE_BIT_B       11
`define CSS_MODE_BIT_F       15
`define CSS_MON_DIR          6
`define CSS_MON_SEL_LO       7
`define CSS_MON_SEL_HI       8
`define CSS_STAT_REVERSE     16
`define CSS_STAT_MODE_LO     18
`define CSS_STAT_RAMPING     21

// reset values
`define CSS_RST_FUNC_SW      16'h0000
`define CSS_RST_MODE_SW      16'h0000
`define CSS_RST_FIRST_PRESET_SPEED       16'h0064
`define CSS_RST_SECOND_PRESET_SPEED       16'h00c8
`define CSS_RST_THIRD_PRESET_SPEED       16'h012c
`define CSS_RST_ACCEL        14'h0000
`define CSS_RST_DECEL        14'h0000

// limits and timing
`define CSS_MAX_SPEED_RPM    4500
`define CSS_RAMP_MAX_MS      14'h2710
`define CSS_CLK_PERIOD_NS    100
`define CSS_MS_IN_NS         1000000
`define CSS_CLK_PER_MS       (`CSS_MS_IN_NS / `CSS_CLK_PERIOD_NS)

`endif

// ### include/css_pkg.sv
/*
 types shared by the contact speed selection block;
 assumes css_defines.svh holds every number
*/
`default_nettype none

package css_pkg;

	typedef enum logic [2:0] {
		REF_STANDARD = 3'b000,
		REF_PRESET   = 3'b001,
		REF_STOP     = 3'b010,
		REF_CLAMP    = 3'b011,
		REF_ANALOG   = 3'b100,
		REF_PULSE    = 3'b101
	} ref_mode_type;

	typedef logic signed [15:0] speed_type;

endpackage

`default_nettype wire

// ### tb/contact_panel.sv
/*
 switch panel model driving the active-low contact pins
 assumes the bench requests contact states just after clk_sys edges
*/
`timescale 1ns/1ps
`default_nettype none

module contact_panel (
	// clock
	input  wire logic       clk_sys,
	// requested states, 1 = on: block, direction, first, second
	input  wire logic [3:0] contactOn,
	// active-low contact pins
	output var  logic       referenceBlockInputN = 1'h1,
	output var  logic       directionSelectInputN = 1'h1,
	output var  logic       speedSelectFirstInputN = 1'h1,
	output var  logic       speedSelectSecondInputN = 1'h1
);
	// contacts settle one edge after a request; no reference pulses are sent
	always @(posedge clk_sys) begin
		{referenceBlockInputN, directionSelectInputN, speedSelectFirstInputN,
			speedSelectSecondInputN} <= ~contactOn;
	end
endmodule

`default_nettype wire

// ### tb/contact_speed_select_sva.sv
/*
 assertions on the contact speed selection ports
 assumes the speed variant and a bind to every instance
*/
`timescale 1ns/1ps
`default_nettype none

module contact_speed_select_sva
	import css_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic         rst,
	input wire logic         directionSelectInputN,
	input wire logic         speedSelectFirstInputN,
	input wire logic         speedSelectSecondInputN,
	input wire speed_type    speedCommand,
	input wire logic         reverseRun,
	input wire logic         propControl,
	input wire logic         fwdTorqueLimit,
	input wire logic         revTorqueLimit,
	input wire ref_mode_type refMode,
	input wire logic         referenceBlock,
	input wire logic         rampBusy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// enable is internal, so the standard path stands in for it
	wire logic ctl = refMode != REF_STANDARD;
	sequence s_selHeld;
		(!speedSelectFirstInputN || !speedSelectSecondInputN)[*4];
	endsequence
	sequence s_offHeld;
		(speedSelectFirstInputN && speedSelectSecondInputN)[*4];
	endsequence
	sequence s_dirHeld;
		$stable(directionSelectInputN)[*4];
	endsequence
	property p_decode;
		s_selHeld ##0 ctl |-> refMode == REF_PRESET;
	endproperty
	a_decode: assert property (p_decode) else $error("preset not decoded");
	property p_stop;
		s_offHeld ##0 ctl |-> refMode inside {REF_STOP, REF_CLAMP, REF_ANALOG};
	endproperty
	a_stop: assert property (p_stop) else $error("bad both-off path");
	property p_dir;
		s_dirHeld ##0 ctl |-> reverseRun == !directionSelectInputN;
	endproperty
	a_dir: assert property (p_dir) else $error("bad direction");
	property p_flags;
		ctl |-> !(propControl || fwdTorqueLimit || revTorqueLimit || referenceBlock);
	endproperty
	a_flags: assert property (p_flags) else $error("standard flags in preset mode");
	property p_noRev;
		!ctl |-> !reverseRun;
	endproperty
	a_noRev: assert property (p_noRev) else $error("reverse while disabled");
	property p_zero;
		refMode != REF_PRESET && !rampBusy |-> speedCommand == 0;
	endproperty
	a_zero: assert property (p_zero) else $error("nonzero settled stop");
	property p_sign;
		refMode == REF_PRESET && !rampBusy |-> (reverseRun ? speedCommand <= 0 : speedCommand >= 0);
	endproperty
	a_sign: assert property (p_sign) else $error("command sign wrong");
	property p_sync;
		refMode == REF_STOP && $fell(speedSelectFirstInputN) |=> (refMode != REF_PRESET)[*2];
	endproperty
	a_sync: assert property (p_sync) else $error("contact not synchronised");
endmodule

bind contact_speed_select contact_speed_select_sva chk_u (.clk_sys, .rst, .directionSelectInputN,
	.speedSelectFirstInputN, .speedSelectSecondInputN, .speedCommand, .reverseRun, .propControl,
	.fwdTorqueLimit, .revTorqueLimit, .refMode, .referenceBlock, .rampBusy);

`default_nettype wire

// ### tb/test_contact_speed_select.sv
/*
 self-checking bench for contact speed selection over apb
 assumes the speed variant, one 10 mhz clock, a shortened ms count
*/
`timescale 1ns/1ps
`default_nettype none

module test_contact_speed_select
	import css_pkg::*;
;
	logic         clk_sys, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic         pready, pslverr, err, reverseRun, propControl, referenceBlock, rampBusy;
	logic         fwdTorqueLimit, revTorqueLimit, directionSelectInputN, referenceBlockInputN;
	logic         speedSelectFirstInputN, speedSelectSecondInputN;
	logic [7:0]   paddr = 8'h0;
	logic [31:0]  pwdata = 32'h0, prdata, rdata;
	logic [3:0]   contactOn = 4'h0;
	speed_type    speedCommand;
	ref_mode_type refMode;
	int           fail_count = 0, total_checks = 0;

	// 5000 clocks per ms keeps a full-scale ramp at one step per clock or less
	contact_speed_select #(.CLK_PER_MS(5000)) dut_u (.clk_sys, .rst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .directionSelectInputN,
		.speedSelectFirstInputN, .speedSelectSecondInputN, .referenceBlockInputN, .speedCommand,
		.reverseRun, .propControl, .fwdTorqueLimit, .revTorqueLimit, .refMode, .referenceBlock,
		.rampBusy);
	contact_panel panel_u (.clk_sys, .contactOn, .referenceBlockInputN, .directionSelectInputN,
		.speedSelectFirstInputN, .speedSelectSecondInputN);

	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do
			@(posedge clk_sys);
		while (pready !== 1'h1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// outputs are read at the falling edge, once every update has landed
	task automatic sel(input logic [3:0] s);
		@(posedge clk_sys);
		contactOn <= s;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic t_reset;
		logic [7:0]  a [7] = '{8'h0, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
		logic [31:0] e [7] = '{32'h0, 32'h0, 32'h64, 32'hc8, 32'h12c, 32'h0, 32'h0};
		for (int i = 0; i < 7; i++) begin
			apb(1'h0, a[i], 32'h0);
			check(rdata, e[i]);
		end
		apb(1'h0, 8'h40, 32'h0);
		check({rdata[30:0], err}, 32'h1);
		$display("reset test done");
	endtask

	task automatic t_standard;
		sel(4'h6);
		check({propControl, fwdTorqueLimit, revTorqueLimit, reverseRun}, 4'hc);
		apb(1'h0, 8'h1c, 32'h0);
		check(rdata[8:6], 3'h3);
		$display("standard test done");
	endtask

	task automatic t_preset;
		logic [31:0] m, spd [4] = '{32'h0, 32'h64, 32'h12c, 32'hc8};
		apb(1'h1, 8'h00, 32'h4);
		for (int i = 0; i < 8; i++) begin
			sel({1'h1, i[2:0]});
			m = spd[i[1:0]];
			check(32'(speedCommand), i[2] ? -m : m);
			check({refMode, reverseRun, referenceBlock}, {m ? REF_PRESET : REF_STOP, i[2], 1'h0});
			apb(1'h0, 8'h1c, 32'h0);
			check(rdata[8:7], {i[0], i[1]});
		end
		apb(1'h1, 8'h08, 32'h1388);
		apb(1'h0, 8'h08, 32'h0);
		check(rdata, 32'h1194);
		$display("preset test done");
	endtask

	task automatic t_modes;
		ref_mode_type e [4] = '{REF_STOP, REF_CLAMP, REF_ANALOG, REF_ANALOG};
		sel(4'h4);
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, 8'h04, {20'h0, i[1:0], 10'h0} | 32'h8000);
			@(posedge clk_sys);
			@(negedge clk_sys);
			check(refMode, e[i]);
		end
		$display("mode test done");
	endtask

	// one step at most per clock, so a mid-ramp value has a small window
	task automatic ramp_to(input logic [3:0] s, input logic [31:0] fin);
		sel(s);
		repeat (2496) @(negedge clk_sys);
		check({rampBusy, speedCommand >= 2240 && speedCommand <= 2260}, 2'h3);
		repeat (2600) @(negedge clk_sys);
		check({rampBusy, 32'(speedCommand)}, {1'h0, fin});
	endtask

	task automatic t_ramp;
		apb(1'h1, 8'h14, 32'h4e20);
		apb(1'h0, 8'h14, 32'h0);
		check(rdata, 32'h2710);
		apb(1'h1, 8'h14, 32'h1);
		apb(1'h1, 8'h18, 32'h1);
		ramp_to(4'h1, 32'h1194);
		ramp_to(4'h0, 32'h0);
		$display("ramp test done");
	endtask

	initial begin
		#3000000;
		fail_count++;
		test_done();
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'h0;
		t_reset();
		t_standard();
		t_preset();
		t_modes();
		t_ramp();
		test_done();
	end
endmodule

`default_nettype wire
